// *** rtl/nvsrc_pkg.sv ***
// package: pin timing, sequence addresses and carrier types for the nvsram host controller
`default_nettype none
package nvsrc_pkg;
   localparam int unsigned CLK_NS        = 10;
   localparam int unsigned ADDR_W        = 13;
   localparam int unsigned DATA_W        = 8;
   // pin phase times in ns, then nv cycle times in ms and us
   localparam int unsigned SETUP_NS      = 20;
   localparam int unsigned STROBE_NS     = 60;
   localparam int unsigned HOLD_NS       = 20;
   localparam int unsigned RECOVER_NS    = 700;
   localparam int unsigned STORE_MS      = 10;
   localparam int unsigned RECALL_US     = 20;
   localparam int unsigned RESTORE_US    = 550;
   localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RECOVER_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned STORE_CYC     = STORE_MS * 1000000 / CLK_NS;
   localparam int unsigned RECALL_CYC    = RECALL_US * 1000 / CLK_NS;
   localparam int unsigned RESTORE_CYC   = RESTORE_US * 1000 / CLK_NS;
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned SEQ_LEN       = 6;
   localparam logic [12:0] SEQ_A0        = 13'h0000;
   localparam logic [12:0] SEQ_A1        = 13'h1555;
   localparam logic [12:0] SEQ_A2        = 13'h0aaa;
   localparam logic [12:0] SEQ_A3        = 13'h1fff;
   localparam logic [12:0] SEQ_A4        = 13'h10f0;
   localparam logic [12:0] SEQ_STORE     = 13'h0f0f;
   localparam logic [12:0] SEQ_RECALL    = 13'h0f0e;

   typedef enum logic [2:0] {NVSRC_READ, NVSRC_WRITE, NVSRC_SWSTORE, NVSRC_SWRECALL,
                             NVSRC_HWSTORE} nvsrc_cmd_e;

   typedef struct packed {
      nvsrc_cmd_e        cmd;
      logic [12:0]       addr;
      logic [7:0]        wdata;
   } nvsrc_req_s;

   typedef struct packed {
      logic              chipEnableN;
      logic              writeEnableN;
      logic              outputEnableN;
      logic              storeBusyOutN;
      logic              storeBusyOeN;
      logic [12:0]       addressPins;
      logic [7:0]        dataOut;
      logic              dataOeN;
   } nvsrc_pins_s;
endpackage : nvsrc_pkg
`default_nettype wire

// *** rtl/nvsrc_cycle.sv ***
// single chip-enable framed bus cycle generator for the nvsram pins
`timescale 1ns/1ps
`default_nettype none
module nvsrc_cycle
   import nvsrc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire logic              isWrite,
   input  wire logic [12:0]       addr,
   input  wire logic [7:0]        wdata,
   input  wire logic [7:0]        dataIn,
   output var  nvsrc_pins_s       pins,
   output logic [7:0]             rdata,
   output logic                   done
);
   import nvsrc_pkg::*;

   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} nvsrc_cy_e;
   typedef struct packed {
      nvsrc_cy_e   st;
      logic [7:0]  cnt;
      logic        wr;
      nvsrc_pins_s pins;
      logic [7:0]  rdata;
      logic        done;
   } nvsrc_cy_s;

   nvsrc_cy_s s_reg;
   nvsrc_cy_s s_next;

   // data pins pass two flops before being read
   logic [7:0] dqMeta_reg;
   logic [7:0] dqSync_reg;

   always_ff @(posedge clk)
   begin
      dqMeta_reg <= dataIn;
      dqSync_reg <= dqMeta_reg;
   end

   always_comb
   begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      case (s_reg.st)
         CY_IDLE:
         begin
            if (start)
            begin
               s_next.st = CY_SETUP;
               s_next.wr = isWrite;
               s_next.cnt = 8'(SETUP_CYC);
               s_next.pins.addressPins = addr;
               s_next.pins.dataOut = wdata;
               // output enable stays high for writes to avoid contention
               s_next.pins.outputEnableN = isWrite;
            end
         end
         CY_SETUP:
         begin
            s_next.cnt = s_reg.cnt - 8'h01;
            if (s_reg.cnt == 8'h01)
            begin
               // each step framed by a chip enable edge
               s_next.st = CY_STROBE;
               s_next.cnt = 8'(STROBE_CYC);
               s_next.pins.chipEnableN = 1'b0;
               s_next.pins.writeEnableN = ~s_reg.wr;
               s_next.pins.dataOeN = ~s_reg.wr;
            end
         end
         CY_STROBE:
         begin
            s_next.cnt = s_reg.cnt - 8'h01;
            if (s_reg.cnt == 8'h01)
            begin
               s_next.st = CY_HOLD;
               s_next.cnt = 8'(HOLD_CYC);
               s_next.rdata = dqSync_reg;
               s_next.pins.chipEnableN = 1'b1;
               s_next.pins.writeEnableN = 1'b1;
               s_next.pins.outputEnableN = 1'b1;
            end
         end
         CY_HOLD:
         begin
            s_next.cnt = s_reg.cnt - 8'h01;
            if (s_reg.cnt == 8'h01)
            begin
               s_next.st = CY_IDLE;
               s_next.done = 1'b1;
               s_next.pins.dataOeN = 1'b1;
            end
         end
         default: s_next.st = CY_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_reg <= '{st: CY_IDLE, cnt: 8'h00, wr: 1'b0, rdata: 8'h00, done: 1'b0,
                    pins: '{chipEnableN: 1'b1, writeEnableN: 1'b1, outputEnableN: 1'b1,
                            storeBusyOutN: 1'b1, storeBusyOeN: 1'b1,
                            addressPins: 13'h0000, dataOut: 8'h00, dataOeN: 1'b1}};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign pins  = s_reg.pins;
   assign rdata = s_reg.rdata;
   assign done  = s_reg.done;

   chk_write_low_strobe: assert property (@(posedge clk) disable iff (rst)
      !pins.writeEnableN |-> !pins.chipEnableN && pins.outputEnableN)
      else $error("write enable low outside a framed write");
endmodule // nvsrc_cycle
`default_nettype wire

// *** rtl/nvsrc_host.sv ***
// host controller driving the nvsram pins: reads, writes, software and hardware nv cycles
// What this block does
// - read with chip and output enable low, write enable and busy high.
// - write with chip and write enable low while busy pin is high.
// - six reads ending 0f0f start a store lasting up to 10 ms.
// - six reads ending 0f0e start a recall finishing within 20 us.
// - write enable stays high through all six sequence reads.
// - every sequence step is clocked by a chip enable pulse.
// - an interrupting access aborts the sequence; no nv operation happens.
// - accesses other than sequence steps two to six stay inhibited while the busy pin is held low.
`timescale 1ns/1ps
`default_nettype none
module nvsrc_host
   import nvsrc_pkg::*;
#(
   parameter int unsigned STORE_WAIT   = STORE_CYC,
   parameter int unsigned RESTORE_WAIT = RESTORE_CYC
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              reqValid,
   input  wire nvsrc_req_s        req,
   output logic                   reqReady,
   output logic                   respValid,
   output logic [7:0]             respData,
   output logic                   chipEnableN,
   output logic                   writeEnableN,
   output logic                   outputEnableN,
   output logic [12:0]            addressPins,
   output logic [7:0]             dataPinsOut,
   output logic                   dataPinsOeN,
   input  wire logic [7:0]        dataPinsIn,
   output logic                   storeBusyOutN,
   output logic                   storeBusyOeN,
   input  wire logic              storeBusyInN
);
   import nvsrc_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {H_BOOT, H_IDLE, H_CYCLE, H_NVWAIT, H_HWLOW, H_HWWAIT,
                             H_RECOVER} nvsrc_st_e;
   typedef struct packed {
      nvsrc_st_e   st;
      logic [CNT_W-1:0] cnt;
      nvsrc_cmd_e  cmd;
      logic [2:0]  step;
      logic [12:0] addr;
      logic [7:0]  wdata;
      logic        ready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic        busyOeN;
   } nvsrc_host_s;

   nvsrc_host_s s_reg;
   nvsrc_host_s s_next;

   logic        busyMeta_reg;
   logic        busySync_reg;
   logic        cyStart;
   logic        cyDone;
   logic [7:0]  cyData;
   nvsrc_pins_s cyPins;

   function automatic logic [12:0] seqAddr(input logic [2:0] idx, input nvsrc_cmd_e c);
      case (idx)
         3'h0:    seqAddr = SEQ_A0;
         3'h1:    seqAddr = SEQ_A1;
         3'h2:    seqAddr = SEQ_A2;
         3'h3:    seqAddr = SEQ_A3;
         3'h4:    seqAddr = SEQ_A4;
         default: seqAddr = (c == NVSRC_SWSTORE) ? SEQ_STORE : SEQ_RECALL;
      endcase
   endfunction

   // busy pin is from the device's domain
   always_ff @(posedge clk)
   begin
      busyMeta_reg <= storeBusyInN;
      busySync_reg <= busyMeta_reg;
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_comb
   begin
      s_next        = s_reg;
      s_next.rvalid = 1'b0;
      cyStart       = 1'b0;
      case (s_reg.st)
         H_BOOT:
         begin
            // nothing touches the array during the power-up recall
            s_next.cnt = s_reg.cnt - CNT_W'(1);
            if (s_reg.cnt == '0)
            begin
               s_next.st = H_IDLE;
               s_next.ready = 1'b1;
            end
         end
         H_IDLE:
         begin
            if (reqValid)
            begin
               s_next.ready = 1'b0;
               s_next.cmd = req.cmd;
               s_next.addr = req.addr;
               s_next.wdata = req.wdata;
               s_next.step = 3'h0;
               if (!busySync_reg)
               begin
                  // device-driven busy: wait it out
                  s_next.st = H_HWWAIT;
               end
               else if (req.cmd == NVSRC_HWSTORE)
               begin
                  s_next.st = H_HWLOW;
                  s_next.busyOeN = 1'b0;
                  s_next.cnt = CNT_W'(STORE_WAIT);
               end
               else
               begin
                  s_next.st = H_CYCLE;
                  cyStart = 1'b1;
               end
            end
         end
         H_CYCLE:
         begin
            if (cyDone)
            begin
               if (s_reg.cmd == NVSRC_READ || s_reg.cmd == NVSRC_WRITE)
               begin
                  s_next.st = H_IDLE;
                  s_next.ready = 1'b1;
                  s_next.rvalid = 1'b1;
                  s_next.rdata = cyData;
               end
               else if (s_reg.step == 3'(SEQ_LEN - 1))
               begin
                  // sixth read triggers; data there is not driven
                  s_next.st = H_NVWAIT;
                  s_next.cnt = (s_reg.cmd == NVSRC_SWSTORE) ? CNT_W'(STORE_WAIT)
                                                            : CNT_W'(RECALL_CYC);
               end
               else
               begin
                  // back to back steps, nothing in between
                  s_next.step = s_reg.step + 3'h1;
                  cyStart = 1'b1;
               end
            end
         end
         H_NVWAIT:
         begin
            // no access while the nv cycle runs
            s_next.cnt = s_reg.cnt - CNT_W'(1);
            if (s_reg.cnt == '0)
            begin
               s_next.st = H_IDLE;
               s_next.ready = 1'b1;
               s_next.rvalid = 1'b1;
               s_next.step = 3'h0;
            end
         end
         H_HWLOW:
         begin
            // hold low for the full store time; device may skip it
            s_next.cnt = s_reg.cnt - CNT_W'(1);
            if (s_reg.cnt == '0)
            begin
               s_next.busyOeN = 1'b1;
               s_next.st = H_HWWAIT;
            end
         end
         H_HWWAIT:
         begin
            if (busySync_reg)
            begin
               s_next.st = H_RECOVER;
               s_next.cnt = CNT_W'(RECOVER_CYC);
            end
         end
         H_RECOVER:
         begin
            // inhibit lift time after busy returns high
            s_next.cnt = s_reg.cnt - CNT_W'(1);
            if (s_reg.cnt == '0)
            begin
               s_next.st = H_IDLE;
               s_next.ready = 1'b1;
               s_next.rvalid = (s_reg.cmd == NVSRC_HWSTORE);
            end
         end
         default: s_next.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_reg <= '{st: H_BOOT, cnt: CNT_W'(RESTORE_WAIT), cmd: NVSRC_READ, step: 3'h0,
                    addr: 13'h0000, wdata: 8'h00, ready: 1'b0, rvalid: 1'b0,
                    rdata: 8'h00, busyOeN: 1'b1};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // pin cycle engine
   // ----------------------------------------
   logic [12:0] cyAddr;
   logic        cyWrite;
   assign cyWrite = (s_next.cmd == NVSRC_WRITE);
   assign cyAddr  = (s_next.cmd == NVSRC_READ || s_next.cmd == NVSRC_WRITE)
                    ? s_next.addr : seqAddr(s_next.step, s_next.cmd);

   nvsrc_cycle u_cycle (
      .clk     (clk),
      .rst     (rst),
      .start   (cyStart),
      .isWrite (cyWrite),
      .addr    (cyAddr),
      .wdata   (s_next.wdata),
      .dataIn  (dataPinsIn),
      .pins    (cyPins),
      .rdata   (cyData),
      .done    (cyDone)
   );

   // deselected between cycles: chip enable high
   assign chipEnableN   = cyPins.chipEnableN;
   assign writeEnableN  = cyPins.writeEnableN;
   assign outputEnableN = cyPins.outputEnableN;
   assign addressPins   = cyPins.addressPins;
   assign dataPinsOut   = cyPins.dataOut;
   assign dataPinsOeN   = cyPins.dataOeN;
   assign storeBusyOutN = 1'b0;
   assign storeBusyOeN  = s_reg.busyOeN;
   assign reqReady      = s_reg.ready;
   assign respValid     = s_reg.rvalid;
   assign respData      = s_reg.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence nvStart;
      s_reg.st == H_CYCLE && cyDone && s_reg.step == 3'(SEQ_LEN - 1)
         && s_reg.cmd != NVSRC_READ && s_reg.cmd != NVSRC_WRITE;
   endsequence

   chk_nv_quiet: assert property (@(posedge clk) disable iff (rst)
      nvStart |=> chipEnableN [*8])
      else $error("access during nv cycle");
   chk_seq_wr_high: assert property (@(posedge clk) disable iff (rst)
      (s_reg.cmd == NVSRC_SWSTORE || s_reg.cmd == NVSRC_SWRECALL) |-> writeEnableN)
      else $error("write enable low in sequence");
   chk_rd_strobes: assert property (@(posedge clk) disable iff (rst)
      !chipEnableN && !outputEnableN |-> writeEnableN && storeBusyOeN)
      else $error("read with write or busy low");
   chk_wr_busy_high: assert property (@(posedge clk) disable iff (rst)
      !writeEnableN |-> storeBusyOeN && busySync_reg)
      else $error("write while busy low");
   chk_busy_inhibit: assert property (@(posedge clk) disable iff (rst)
      !storeBusyOeN |-> chipEnableN)
      else $error("access while driving busy");
   // a new nv request must open on the first sequence address, not resume
   chk_step_zero: assert property (@(posedge clk) disable iff (rst)
      s_reg.st == H_IDLE && reqValid && busySync_reg
         && (req.cmd == NVSRC_SWSTORE || req.cmd == NVSRC_SWRECALL)
      |=> addressPins == SEQ_A0)
      else $error("sequence not restarted");
   chk_recover_len: assert property (@(posedge clk) disable iff (rst)
      s_reg.st == H_HWWAIT && busySync_reg |=> s_reg.st == H_RECOVER [*8])
      else $error("recovery too short");
   chk_boot_quiet: assert property (@(posedge clk) disable iff (rst)
      s_reg.st == H_BOOT |-> chipEnableN && !reqReady)
      else $error("access during power-up recall");
endmodule // nvsrc_host
`default_nettype wire

// *** tb/nvsrc_sram_model.sv ***
// behavioural nvsram device model facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nvsrc_sram_model
   import nvsrc_pkg::*;
#(
   parameter int STORE_NS  = 300,
   parameter int RECALL_NS = 200
)
(
   input  wire logic        rst,
   input  wire logic        chipEnableN,
   input  wire logic        writeEnableN,
   input  wire logic        outputEnableN,
   input  wire logic [12:0] addressPins,
   input  wire logic [7:0]  dataIn,
   input  wire logic        busyIn,
   input  wire logic        droop,
   output logic [7:0]       dataOut,
   output logic             dataDrive,
   output logic             busyPullN,
   output logic [31:0]      storeCount,
   output logic [31:0]      recallCount,
   output logic [31:0]      badAccess
);
   // ------------------------------
   // array, nv cells, step detector
   // ------------------------------
   logic [7:0]  mem [0:8191];
   logic [7:0]  nvMem [0:8191];
   logic [12:0] seqTab [0:4];
   logic [2:0]  step = 3'h0;
   logic        written = 1'b0;
   logic        nvBusy = 1'b0;
   logic        sixth;
   event        storeGo;
   event        recallGo;

   initial
   begin
      seqTab = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
      storeCount = 32'h0;
      recallCount = 32'h0;
      badAccess = 32'h0;
      busyPullN = 1'b1;
      for (int i = 0; i < 8192; i++)
         nvMem[i] = i[7:0];
   end

   assign sixth = step == 3'h5 && (addressPins == SEQ_STORE || addressPins == SEQ_RECALL);
   assign dataOut = mem[addressPins];
   // the triggering read floats the bus
   assign dataDrive = !chipEnableN && !outputEnableN && writeEnableN && busyIn && !nvBusy
                      && !sixth;

   always @*
   begin
      if (!chipEnableN && !writeEnableN && busyIn && !nvBusy)
      begin
         mem[addressPins] = dataIn;
         written = 1'b1;
         step = 3'h0;
      end
   end

   // output enable is not looked at here
   always @(posedge chipEnableN)
   begin
      if (writeEnableN && busyIn && !nvBusy)
      begin
         if (sixth && addressPins == SEQ_STORE)
            -> storeGo;
         if (sixth && addressPins == SEQ_RECALL)
            -> recallGo;
         if (sixth)
            step = 3'h0;
         else if (step < 3'h5 && addressPins == seqTab[step])
            step = step + 3'h1;
         else
            step = {2'h0, addressPins == SEQ_A0};
      end
   end

   always @(negedge chipEnableN)
      if (nvBusy || !busyIn)
         badAccess = badAccess + 32'h1;

   task automatic run_nv(input int holdNs, input logic toNv, input logic onlyIfWritten);
   begin
      busyPullN = !toNv;
      // an access already under way keeps the array until the grace time ends
      #holdNs;
      nvBusy = 1'b1;
      if (written || !onlyIfWritten)
      begin
         #(toNv ? STORE_NS : RECALL_NS);
         if (toNv)
            nvMem = mem;
         else
            mem = nvMem;
         if (toNv)
            storeCount = storeCount + 32'h1;
         else
            recallCount = recallCount + 32'h1;
         written = 1'b0;
      end
      busyPullN = 1'b1;
      nvBusy = 1'b0;
   end
   endtask

   always @(storeGo) run_nv(0, 1'b1, 1'b0);
   always @(recallGo) run_nv(0, 1'b0, 1'b0);
   always @(negedge rst) run_nv(0, 1'b0, 1'b0);
   always @(posedge droop) run_nv(1000, 1'b1, 1'b1);
   always @(negedge busyIn)
      if (busyPullN && !nvBusy)
         run_nv(0, 1'b1, 1'b1);
endmodule // nvsrc_sram_model
`default_nettype wire

// *** tb/nvsrc_host_bench.sv ***
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module nvsrc_host_bench;
   import nvsrc_pkg::*;
   // --------------------
   // pins and bus wiring
   // --------------------
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        reqValid = 1'b0;
   logic        droop = 1'b0;
   nvsrc_req_s  req = '0;
   logic        reqReady, respValid, ceN, weN, oeN, hOeN, sbOut, sbOeN, mDrive, mPullN;
   logic [7:0]  respData, hData, mData, lastBus = 8'h00;
   logic [12:0] addr;
   logic [31:0] stores, recalls, bad;
   wire  [7:0]  bus;
   wire         busy;
   int          failures = 0;
   int          checked = 0;
   logic [12:0] tabA [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   logic [7:0]  tabD [0:4] = '{8'h11, 8'ha5, 8'h5a, 8'hee, 8'h96};

   // released lines show the inverse of the last driven value
   assign bus = !hOeN ? hData : (mDrive ? mData : ~lastBus);
   assign busy = (sbOeN ? 1'b1 : sbOut) & mPullN;
   always @(hData, mData, hOeN, mDrive)
      if (!hOeN)
         lastBus = hData;
      else if (mDrive)
         lastBus = mData;
   always #5 clk = ~clk;

   nvsrc_host #(.STORE_WAIT(50), .RESTORE_WAIT(30)) DUT (.clk(clk), .rst(rst),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .respValid(respValid),
      .respData(respData), .chipEnableN(ceN), .writeEnableN(weN), .outputEnableN(oeN),
      .addressPins(addr), .dataPinsOut(hData), .dataPinsOeN(hOeN), .dataPinsIn(bus),
      .storeBusyOutN(sbOut), .storeBusyOeN(sbOeN), .storeBusyInN(busy));
   nvsrc_sram_model MODEL (.rst(rst), .chipEnableN(ceN), .writeEnableN(weN),
      .outputEnableN(oeN), .addressPins(addr), .dataIn(bus), .busyIn(busy), .droop(droop),
      .dataOut(mData), .dataDrive(mDrive), .busyPullN(mPullN), .storeCount(stores),
      .recallCount(recalls), .badAccess(bad));

   task check(input logic [31:0] seen, input logic [31:0] expv);
   begin
      checked++;
      if (seen !== expv)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
      end
   end
   endtask

   task test_done;
   begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   task op(input nvsrc_cmd_e c, input logic [12:0] a, input logic [7:0] d,
           output logic [7:0] q);
      int n;
   begin
      n = 0;
      @(negedge clk);
      req.cmd = c;
      req.addr = a;
      req.wdata = d;
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && n < 9000)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      @(negedge clk);
      reqValid = 1'b0;
      while (respValid !== 1'b1 && n < 9000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 9000)
      begin
         failures++;
         $display("MISMATCH at %0t: no response", $time);
      end
      q = respData;
   end
   endtask

   task t_rw;
      logic [7:0] q;
   begin
      for (int i = 0; i < 5; i++)
         op(NVSRC_WRITE, tabA[i], tabD[i], q);
      for (int i = 0; i < 5; i++)
      begin
         op(NVSRC_READ, tabA[i], 8'h00, q);
         check(q, tabD[i]);
      end
      $display("test rw done");
   end
   endtask

   // sequence built from single reads, then a lone last step
   task t_manual;
      logic [7:0] q;
      logic [31:0] s0;
   begin
      s0 = stores;
      for (int i = 0; i < 5; i++)
      begin
         op(NVSRC_READ, tabA[i], 8'h00, q);
         check(q, tabD[i]);
      end
      op(NVSRC_READ, SEQ_STORE, 8'h00, q);
      check(q, 8'(~tabD[4]));
      repeat (40) @(negedge clk);
      check(stores, s0 + 32'h1);
      op(NVSRC_READ, SEQ_STORE, 8'h00, q);
      check(q, 8'h0f);
      check(stores, s0 + 32'h1);
      $display("test manual sequence done");
   end
   endtask

   task t_abort;
      logic [7:0] q;
      logic [31:0] s0;
   begin
      s0 = stores;
      for (int i = 0; i < 3; i++)
         op(NVSRC_READ, tabA[i], 8'h00, q);
      op(NVSRC_WRITE, tabA[2], tabD[2], q);
      for (int i = 3; i < 5; i++)
         op(NVSRC_READ, tabA[i], 8'h00, q);
      op(NVSRC_READ, SEQ_STORE, 8'h00, q);
      check(q, 8'h0f);
      repeat (40) @(negedge clk);
      check(stores, s0);
      $display("test abort done");
   end
   endtask

   task t_sw;
      logic [7:0] q;
      logic [31:0] s0;
      logic [31:0] r0;
   begin
      s0 = stores;
      r0 = recalls;
      op(NVSRC_WRITE, 13'h0100, 8'hc3, q);
      op(NVSRC_SWSTORE, 13'h0000, 8'h00, q);
      check(stores, s0 + 32'h1);
      op(NVSRC_WRITE, 13'h0100, 8'h3c, q);
      op(NVSRC_SWRECALL, 13'h0000, 8'h00, q);
      check(recalls, r0 + 32'h1);
      op(NVSRC_READ, 13'h0100, 8'h00, q);
      check(q, 8'hc3);
      $display("test software nv done");
   end
   endtask

   task t_hw;
      logic [7:0] q;
      logic [31:0] s0;
   begin
      s0 = stores;
      op(NVSRC_HWSTORE, 13'h0000, 8'h00, q);
      check(stores, s0);
      op(NVSRC_WRITE, 13'h0300, 8'h44, q);
      op(NVSRC_HWSTORE, 13'h0000, 8'h00, q);
      check(stores, s0 + 32'h1);
      op(NVSRC_READ, 13'h0300, 8'h00, q);
      check(q, 8'h44);
      $display("test hardware store done");
   end
   endtask

   task t_droop;
      logic [7:0] q;
      logic [31:0] s0;
   begin
      s0 = stores;
      op(NVSRC_WRITE, 13'h0200, 8'h77, q);
      droop = 1'b1;
      repeat (50) @(negedge clk);
      check(busy, 1'b0);
      repeat (150) @(negedge clk);
      droop = 1'b0;
      check(stores, s0 + 32'h1);
      op(NVSRC_READ, 13'h0200, 8'h00, q);
      check(q, 8'h77);
      droop = 1'b1;
      repeat (110) @(negedge clk);
      check(busy, 1'b1);
      check(stores, s0 + 32'h1);
      droop = 1'b0;
      check(bad, 32'h0);
      $display("test supply droop done");
   end
   endtask

   initial
   begin
      #500000;
      failures++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done;
   end

   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_rw;
      t_manual;
      t_abort;
      t_sw;
      t_hw;
      t_droop;
      test_done;
   end
endmodule // nvsrc_host_bench
`default_nettype wire
